// >>> rtl/mtsie_pkg.sv
// constants shared by the timer, status and interrupt enable logic
package mtsie_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 10;
  localparam int TICK_US           = 1;
  localparam int TICK_CYCLES       = TICK_US * CLK_MHZ;
  localparam int SE0_MIN_US        = 8;
  localparam int SE0_MIN_CYCLES    = SE0_MIN_US * CLK_MHZ;
  localparam int WAKE_SHORT_US     = 128;
  localparam int WAKE_SHORT_CYCLES = WAKE_SHORT_US * CLK_MHZ;
  localparam int WAKE_LONG_MS      = 128;
  localparam int WAKE_LONG_CYCLES  = WAKE_LONG_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // timer geometry
  // ----------------------------------------------------------------
  localparam int TIMER_WIDTH     = 12;
  localparam int SHORT_IRQ_BITS  = 7;
  localparam int LONG_IRQ_BITS   = 10;

  // ----------------------------------------------------------------
  // i/o register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] ADDR_TIMER_COUNT_LOW   = 8'h24;
  localparam logic [7:0] ADDR_TIMER_COUNT_HIGH  = 8'h25;
  localparam logic [7:0] ADDR_PROC_STATUS_CTRL  = 8'hff;

  // ----------------------------------------------------------------
  // processor status and control fields
  // ----------------------------------------------------------------
  localparam int PSC_RUN     = 0;
  localparam int PSC_STEP    = 1;
  localparam int PSC_IMASK   = 2;
  localparam int PSC_SUSPEND = 3;
  localparam int PSC_POR     = 4;
  localparam int PSC_BUSRST  = 5;
  localparam int PSC_WDR     = 6;
  localparam int PSC_PENDING = 7;
  localparam logic [7:0] PSC_POR_VALUE = 8'h11;
  localparam logic [7:0] PSC_WDR_VALUE = 8'h41;

  // ----------------------------------------------------------------
  // global enable fields and interrupt sources
  // ----------------------------------------------------------------
  localparam int GIE_BUSRST = 0;
  localparam int GIE_SHORT  = 1;
  localparam int GIE_LONG   = 2;
  localparam int GIE_DAC    = 4;
  localparam int GIE_GPIO   = 5;
  localparam logic [7:0] GIE_WRITE_MASK = 8'h37 & 8'hf7;
  localparam logic [7:0] GIE_RESET      = 8'h00;

  localparam int NUM_SRC = 5;
  localparam int SRC_BUSRST = 0;
  localparam int SRC_SHORT  = 1;
  localparam int SRC_LONG   = 2;
  localparam int SRC_DAC    = 3;
  localparam int SRC_GPIO   = 4;

  localparam logic [13:0] VEC_RESET  = 14'h0000;
  localparam logic [13:0] VEC_BUSRST = 14'h0002;
  localparam logic [13:0] VEC_SHORT  = 14'h0004;
  localparam logic [13:0] VEC_LONG   = 14'h0006;
  localparam logic [13:0] VEC_DAC    = 14'h0014;
  localparam logic [13:0] VEC_GPIO   = 14'h0016;

  // ----------------------------------------------------------------
  // suspend sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MTS_ACTIVE  = 2'b00,
    MTS_SUSPEND = 2'b01,
    MTS_WAKE    = 2'b10
  } mts_power_type;

endpackage

// >>> rtl/mtsie_timer.sv
// free-running 12-bit microsecond timer with coherent two-byte read
`timescale 1ns/1ns
module mtsie_timer
  import mtsie_pkg::*;
#(
  parameter int WIDTH = TIMER_WIDTH
) (
  input  wire logic             clk_sys_i,   // system clock
  input  wire logic             clr_i,       // any reset, sync
  input  wire logic             rd_low_i,    // low byte read strobe
  output logic [WIDTH-1:0]      count_o,     // live count
  output logic [WIDTH-9:0]      held_high_o, // upper bits held at low read
  output logic                  short_o,     // 128-count boundary pulse
  output logic                  long_o       // 1024-count boundary pulse
);

  // ----------------------------------------------------------------
  // microsecond divider
  // ----------------------------------------------------------------
  logic [7:0] div_cnt;
  logic       tick;

  assign tick = (div_cnt == 8'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_i) begin
    if (clr_i || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // counter and boundary pulses
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] next_count;

  assign next_count = count_o + WIDTH'(1);

  always_ff @(posedge clk_sys_i) begin
    if (clr_i) begin
      count_o <= '0;
    end else if (tick) begin
      count_o <= next_count;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (clr_i) begin
      short_o <= 1'b0;
      long_o  <= 1'b0;
    end else begin
      short_o <= tick && (next_count[SHORT_IRQ_BITS-1:0] == '0);
      long_o  <= tick && (next_count[LONG_IRQ_BITS-1:0] == '0);
    end
  end

  // hold upper bits on low read
  always_ff @(posedge clk_sys_i) begin
    if (clr_i) begin
      held_high_o <= '0;
    end else if (rd_low_i) begin
      held_high_o <= count_o[WIDTH-1:8];
    end
  end

endmodule

// >>> rtl/mtsie_core.sv
// system control: timer, processor status/control, interrupt enables
`timescale 1ns/1ns
module mtsie_core
  import mtsie_pkg::*;
#(
  parameter int WAKE_LONG  = WAKE_LONG_CYCLES,
  parameter int WAKE_SHORT = WAKE_SHORT_CYCLES
) (
  input  wire logic        clk_sys_i,                          // clock
  input  wire logic        rst_i,                              // power-on
  input  wire logic        wdog_reset_i,                       // watchdog rst
  input  wire logic [7:0]  io_addr_i,                          // i/o address
  input  wire logic        io_write_instruction_i,             // write strobe
  input  wire logic        io_read_instruction_i,              // read strobe
  input  wire logic [7:0]  io_wdata_i,                         // write data
  input  wire logic        instr_last_cycle_i,                 // instr end
  input  wire logic        halt_instruction_i,                 // halt op
  input  wire logic        disable_interrupts_instruction_i,   // irq off op
  input  wire logic        enable_interrupts_instruction_i,    // irq on op
  input  wire logic        return_from_interrupt_instruction_i,// return op
  input  wire logic        usb_dp_i,                           // d+ pin
  input  wire logic        usb_dm_i,                           // d- pin
  input  wire logic        bus_activity_i,                     // sie activity
  input  wire logic        dac_irq_i,                          // dac event
  input  wire logic        gpio_irq_i,                         // gpio event
  output logic [7:0]       io_rdata_o,                         // read data
  output logic             cpu_run_o,                          // core may run
  output logic             suspend_o,                          // low power
  output logic             irq_call_o,                         // vector call
  output logic [13:0]      irq_vector_o                        // call target
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NUM_SRC-1:0] first_one(
    input logic [NUM_SRC-1:0] req
  );
    logic [NUM_SRC-1:0] sel;
    sel = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        sel = '0;
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction

  function automatic logic [13:0] vector_of(
    input logic [NUM_SRC-1:0] sel
  );
    logic [13:0] v;
    v = VEC_RESET;
    if (sel[SRC_BUSRST]) v = VEC_BUSRST;
    if (sel[SRC_SHORT])  v = VEC_SHORT;
    if (sel[SRC_LONG])   v = VEC_LONG;
    if (sel[SRC_DAC])    v = VEC_DAC;
    if (sel[SRC_GPIO])   v = VEC_GPIO;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // resets and i/o decode
  // ----------------------------------------------------------------
  logic any_rst;
  logic wr_gie;
  logic wr_psc;
  logic rd_low;

  assign any_rst = rst_i || wdog_reset_i;
  assign wr_gie  = io_write_instruction_i &&
                   (io_addr_i == ADDR_GLOBAL_IRQ_ENABLE);
  assign wr_psc  = io_write_instruction_i &&
                   (io_addr_i == ADDR_PROC_STATUS_CTRL);
  assign rd_low  = io_read_instruction_i &&
                   (io_addr_i == ADDR_TIMER_COUNT_LOW);

  // ----------------------------------------------------------------
  // timer
  // ----------------------------------------------------------------
  logic [TIMER_WIDTH-1:0] tmr_count;
  logic [3:0]             tmr_held;
  logic                   tmr_short;
  logic                   tmr_long;

  mtsie_timer #(
    .WIDTH       (TIMER_WIDTH)
  ) u_timer (
    .clk_sys_i   (clk_sys_i),
    .clr_i       (any_rst),
    .rd_low_i    (rd_low),
    .count_o     (tmr_count),
    .held_high_o (tmr_held),
    .short_o     (tmr_short),
    .long_o      (tmr_long)
  );

  // ----------------------------------------------------------------
  // bus reset detection
  // ----------------------------------------------------------------
  logic [1:0] dp_sync;
  logic [1:0] dm_sync;
  logic [7:0] se0_cnt;
  logic       busrst_evt;

  always_ff @(posedge clk_sys_i) begin
    dp_sync <= {dp_sync[0], usb_dp_i};
    dm_sync <= {dm_sync[0], usb_dm_i};
  end

  // both lines low counts as se0
  always_ff @(posedge clk_sys_i) begin
    if (any_rst || dp_sync[1] || dm_sync[1]) begin
      se0_cnt <= 8'h00;
    end else if (se0_cnt <= 8'(SE0_MIN_CYCLES)) begin
      se0_cnt <= se0_cnt + 8'h01;
    end
  end

  // one event when se0 exceeds minimum
  assign busrst_evt = !dp_sync[1] && !dm_sync[1] &&
                      (se0_cnt == 8'(SE0_MIN_CYCLES));

  // ----------------------------------------------------------------
  // interrupt latches and enables
  // ----------------------------------------------------------------
  logic [7:0]         gie;
  logic [NUM_SRC-1:0] src_evt;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] latch;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] take_sel;
  logic               any_pend;
  logic               gie_state;
  logic               ack;

  // bus reset feeds an interrupt latch and also sets the bus reset status flag
  assign src_evt = {gpio_irq_i, dac_irq_i, tmr_long, tmr_short,
                    busrst_evt};
  assign src_en  = {gie[GIE_GPIO], gie[GIE_DAC], gie[GIE_LONG],
                    gie[GIE_SHORT], gie[GIE_BUSRST]};
  assign pend     = latch & src_en;
  assign any_pend = |pend;
  assign take_sel = first_one(pend);
  assign ack      = instr_last_cycle_i && cpu_run_o && gie_state &&
                    any_pend;

  // enable register, reserved bits held zero
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      gie <= GIE_RESET;
    end else if (wr_gie) begin
      gie <= io_wdata_i & GIE_WRITE_MASK;
    end
  end

  // latch clear on acknowledge; a new event wins
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      latch <= '0;
    end else begin
      latch <= (latch & ~(ack ? take_sel : '0)) | src_evt;
    end
  end

  // global enable set by instructions, cleared by instructions and on acknowledge
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      gie_state <= 1'b0;
    end else if (ack || disable_interrupts_instruction_i) begin
      gie_state <= 1'b0;
    end else if (enable_interrupts_instruction_i ||
                 return_from_interrupt_instruction_i) begin
      gie_state <= 1'b1;
    end
  end

  // call the vector of the serviced source
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      irq_call_o   <= 1'b0;
      irq_vector_o <= VEC_RESET;
    end else begin
      irq_call_o <= ack;
      if (ack) begin
        irq_vector_o <= vector_of(take_sel);
      end
    end
  end

  // ----------------------------------------------------------------
  // suspend sequencer
  // ----------------------------------------------------------------
  mts_power_type pwr;
  logic [7:0]    psc;
  logic [20:0]   wake_cnt;
  logic          susp_req;
  logic          wake_cause;

  assign susp_req   = wr_psc && io_wdata_i[PSC_SUSPEND] &&
                      !bus_activity_i && !any_pend;
  assign wake_cause = bus_activity_i || any_pend;

  // enter suspend and leave on wake cause
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      pwr      <= MTS_ACTIVE;
      wake_cnt <= '0;
    end else begin
      case (pwr)
        MTS_ACTIVE: begin
          if (susp_req) begin
            pwr <= MTS_SUSPEND;
          end
        end
        MTS_SUSPEND: begin
          if (wake_cause) begin
            pwr <= MTS_WAKE;
            // start-up delay chosen by power-on flag
            wake_cnt <= psc[PSC_POR] ? 21'(WAKE_LONG - 1)
                                     : 21'(WAKE_SHORT - 1);
          end
        end
        MTS_WAKE: begin
          if (wake_cnt == '0) begin
            pwr <= MTS_ACTIVE;
          end else begin
            wake_cnt <= wake_cnt - 21'h00_0001;
          end
        end
        default: begin
          pwr <= MTS_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // processor status and control
  // ----------------------------------------------------------------
  logic [7:0] psc_rd;
  logic       next_run;

  // halt and single step clear run
  always_comb begin
    next_run = psc[PSC_RUN];
    // firmware keeps run written as one
    if (wr_psc) begin
      next_run = io_wdata_i[PSC_RUN];
    end
    if (instr_last_cycle_i && cpu_run_o &&
        (halt_instruction_i || psc[PSC_STEP])) begin
      next_run = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      psc <= PSC_POR_VALUE;
    end else if (wdog_reset_i) begin
      psc <= PSC_WDR_VALUE;
    end else begin
      psc[PSC_RUN] <= next_run;
      if (wr_psc) begin
        psc[PSC_STEP] <= io_wdata_i[PSC_STEP];
        psc[PSC_POR]  <= psc[PSC_POR] & io_wdata_i[PSC_POR];
        psc[PSC_WDR]  <= io_wdata_i[PSC_WDR];
      end
      // bus reset flag, hardware set wins
      psc[PSC_BUSRST] <= busrst_evt ||
                         (wr_psc ? io_wdata_i[PSC_BUSRST]
                                 : psc[PSC_BUSRST]);
      psc[PSC_SUSPEND] <= (pwr == MTS_SUSPEND) ? !wake_cause
                                               : susp_req;
      psc[PSC_PENDING] <= ack ? |(src_evt & src_en)
                              : (psc[PSC_PENDING] || any_pend);
      psc[PSC_IMASK] <= 1'b0;
    end
  end

  // mask bit reflects live enable state
  always_comb begin
    psc_rd = psc;
    psc_rd[PSC_IMASK] = gie_state;
  end

  // ----------------------------------------------------------------
  // run and suspend outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      cpu_run_o <= 1'b1;
      suspend_o <= 1'b0;
    end else begin
      cpu_run_o <= next_run && (pwr == MTS_ACTIVE) && !susp_req;
      suspend_o <= (pwr == MTS_SUSPEND && !wake_cause) || susp_req;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // register read map
  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      io_rdata_o <= 8'h00;
    end else if (io_read_instruction_i) begin
      case (io_addr_i)
        ADDR_GLOBAL_IRQ_ENABLE: io_rdata_o <= gie;
        ADDR_TIMER_COUNT_LOW:   io_rdata_o <= tmr_count[7:0];
        ADDR_TIMER_COUNT_HIGH:  io_rdata_o <= {4'h0, tmr_held};
        ADDR_PROC_STATUS_CTRL:  io_rdata_o <= psc_rd;
        default:                io_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// >>> bench/mtsie_monitor.sv
// checker for the timer, status and interrupt enable block
`timescale 1ns/1ns
module mtsie_monitor (
  input wire logic        clk_sys_i,              // clock
  input wire logic        rst_i,                  // power-on reset
  input wire logic        wdog_reset_i,           // watchdog reset
  input wire logic [7:0]  io_addr_i,              // i/o address
  input wire logic        io_write_instruction_i, // write strobe
  input wire logic        io_read_instruction_i,  // read strobe
  input wire logic [7:0]  io_wdata_i,             // write data
  input wire logic        instr_last_cycle_i,     // instruction end
  input wire logic        halt_instruction_i,     // halt op
  input wire logic        bus_activity_i,         // bus activity
  input wire logic [7:0]  io_rdata_o,             // read data
  input wire logic        cpu_run_o,              // core may run
  input wire logic        suspend_o,              // low power
  input wire logic        irq_call_o,             // vector call
  input wire logic [13:0] irq_vector_o            // call target
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || wdog_reset_i);

  sequence halt_end;
    instr_last_cycle_i && halt_instruction_i && cpu_run_o;
  endsequence
  sequence sus_req;
    io_write_instruction_i && io_addr_i == 8'hff && io_wdata_i[3];
  endsequence

  reset_state_a: assert property (
    $fell(rst_i) |-> cpu_run_o && !suspend_o && !irq_call_o)
    else $error("state after reset is wrong");
  high_nibble_a: assert property (
    io_read_instruction_i && io_addr_i == 8'h25 |=> io_rdata_o[7:4] == 4'h0)
    else $error("reserved timer bits not zero");
  halt_stop_a: assert property (
    halt_end |=> (!cpu_run_o) [*8])
    else $error("core not stopped after halt");
  call_pulse_a: assert property (
    irq_call_o |=> !irq_call_o)
    else $error("vector call longer than one cycle");
  vector_ok_a: assert property (
    irq_call_o |-> irq_vector_o inside {14'h0002, 14'h0004, 14'h0006,
                                        14'h0014, 14'h0016})
    else $error("vector call to an unknown address");
  call_timing_a: assert property (
    irq_call_o |-> $past(instr_last_cycle_i) && $past(cpu_run_o))
    else $error("call not at an instruction end");
  suspend_refuse_a: assert property (
    sus_req ##0 bus_activity_i && !suspend_o |=> !suspend_o)
    else $error("suspend taken during bus activity");
  suspend_stop_a: assert property (
    suspend_o |-> !cpu_run_o)
    else $error("core runs in suspend");
  wake_up_a: assert property (
    suspend_o && bus_activity_i |-> ##[1:3] !suspend_o)
    else $error("bus activity did not end suspend");
endmodule

bind mtsie_core mtsie_monitor u_mon (
  .clk_sys_i, .rst_i, .wdog_reset_i, .io_addr_i, .io_write_instruction_i,
  .io_read_instruction_i, .io_wdata_i, .instr_last_cycle_i,
  .halt_instruction_i, .bus_activity_i, .io_rdata_o, .cpu_run_o,
  .suspend_o, .irq_call_o, .irq_vector_o
);

// >>> bench/mtsie_cpu_model.sv
// processor core model: marks the end of each four-cycle instruction
`timescale 1ns/1ns
module mtsie_cpu_model (
  input  wire logic clk_sys_i, // clock
  input  wire logic rst_i,     // any reset
  input  wire logic run_i,     // core may run
  output logic      last_o     // last cycle of instruction
);
  logic [1:0] phase;

  // no instruction ends while stopped
  always @(negedge clk_sys_i) begin
    if (rst_i || !run_i) begin
      phase <= 2'h0;
      last_o <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      last_o <= phase == 2'h3;
    end
  end
endmodule

// >>> bench/tb.sv
// self-checking bench for the timer, status and interrupt enable block
`timescale 1ns/1ns
module tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wdog = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0, rd = 1'b0, halt = 1'b0, bus = 1'b0;
  logic        irq_off = 1'b0, irq_on = 1'b0, irq_ret = 1'b0;
  logic        dp = 1'b1, dm = 1'b0, dac = 1'b0, gpio = 1'b0;
  logic        last, run, sus, call;
  logic [7:0]  rdata, l1, l2;
  logic [13:0] vec;
  logic [7:0]  en_t [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h01};
  logic [15:0] vec_t [5] = '{16'h0004, 16'h0006, 16'h0014, 16'h0016,
                             16'h0002};
  int          num_errors = 0, n_tests = 0, cyc = 0, i, k;

  mtsie_core #(.WAKE_LONG(200)) DUT (
    .clk_sys_i, .rst_i, .wdog_reset_i(wdog), .io_addr_i(addr),
    .io_write_instruction_i(wr), .io_read_instruction_i(rd),
    .io_wdata_i(wdata), .instr_last_cycle_i(last),
    .halt_instruction_i(halt), .disable_interrupts_instruction_i(irq_off),
    .enable_interrupts_instruction_i(irq_on),
    .return_from_interrupt_instruction_i(irq_ret), .usb_dp_i(dp),
    .usb_dm_i(dm), .bus_activity_i(bus), .dac_irq_i(dac),
    .gpio_irq_i(gpio), .io_rdata_o(rdata), .cpu_run_o(run),
    .suspend_o(sus), .irq_call_o(call), .irq_vector_o(vec));
  mtsie_cpu_model u_cpu (.clk_sys_i, .rst_i(rst_i | wdog), .run_i(run),
    .last_o(last));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string s, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr_io(input logic [7:0] a, d);
    @(negedge clk_sys_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask
  task automatic rd_io(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    d = rdata;
  endtask
  // read, mask and compare
  task automatic rd_chk(input logic [7:0] a, m, e);
    logic [7:0] d;
    rd_io(a, d);
    check($sformatf("reg %h", a), {8'h00, e}, {8'h00, d & m});
  endtask
  // one-cycle pulse of {irq_off, irq_on, irq_ret}
  task automatic op(input logic [2:0] o);
    @(negedge clk_sys_i);
    {irq_off, irq_on, irq_ret} = o;
    @(negedge clk_sys_i);
    {irq_off, irq_on, irq_ret} = 3'h0;
  endtask
  task automatic do_rst(input logic w);
    @(negedge clk_sys_i);
    wdog = w;
    rst_i = ~w;
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    wdog = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      final_report;
    end
  end

  initial begin
    do_rst(1'b0);
    rd_chk(8'hff, 8'hff, 8'h11);
    rd_chk(8'h20, 8'hff, 8'h00);
    wr_io(8'h20, 8'hff);
    rd_chk(8'h20, 8'hff, 8'h37);
    rd_chk(8'h30, 8'hff, 8'h00);
    wr_io(8'h20, 8'h00);
    $display("test registers done");
    repeat (3000) @(negedge clk_sys_i);
    rd_io(8'h24, l1);
    repeat (998) @(negedge clk_sys_i);
    rd_io(8'h24, l2);
    check("tick", 16'h0064, {8'h00, l2 - l1});
    repeat (4000) @(negedge clk_sys_i);
    rd_chk(8'h25, 8'hff, 8'h01);
    $display("test timer done");
    for (i = 0; i < 5; i++) begin
      @(negedge clk_sys_i);
      dac = i == 2;
      gpio = i == 3;
      @(negedge clk_sys_i);
      dac = 1'b0;
      gpio = 1'b0;
      if (i == 4) begin
        dp = 1'b0;
        dm = 1'b1;
        repeat (120) @(negedge clk_sys_i);
        rd_chk(8'hff, 8'h20, 8'h00);
        dm = 1'b0;
        repeat (120) @(negedge clk_sys_i);
        dp = 1'b1;
      end
      op(3'b100);
      wr_io(8'h20, en_t[i]);
      op(3'b010);
      for (k = 0; k < 12000 && call !== 1'b1; k++) @(negedge clk_sys_i);
      check("vector", vec_t[i], {2'b00, vec});
      rd_chk(8'hff, 8'h84, 8'h00);
    end
    rd_chk(8'hff, 8'h20, 8'h20);
    check("run", 16'h0001, {15'h0000, run});
    wr_io(8'h20, 8'h00);
    wr_io(8'hff, 8'h95);
    rd_chk(8'hff, 8'h84, 8'h00);
    op(3'b001);
    rd_chk(8'hff, 8'h84, 8'h04);
    $display("test interrupts done");
    bus = 1'b1;
    wr_io(8'hff, 8'h19);
    check("suspend", 16'h0000, {15'h0000, sus});
    bus = 1'b0;
    wr_io(8'hff, 8'h19);
    check("suspend", 16'h0002, {14'h0000, sus, run});
    repeat (20) @(negedge clk_sys_i);
    bus = 1'b1;
    @(negedge clk_sys_i);
    bus = 1'b0;
    for (k = 0; k < 3000 && run !== 1'b1; k++) @(negedge clk_sys_i);
    check("wake", 16'h0001, {14'h0000, sus, run});
    // power-on flag set: long start-up of 200 cycles, not the 1280 one
    check("wake delay", 16'h0001, {15'h0000, k > 150 && k < 400});
    wr_io(8'hff, 8'h13);
    for (k = 0; k < 20 && run !== 1'b0; k++) @(negedge clk_sys_i);
    check("step", 16'h0000, {15'h0000, run});
    $display("test control done");
    wr_io(8'h20, 8'h37);
    rd_chk(8'hff, 8'h80, 8'h80);
    do_rst(1'b1);
    rd_chk(8'hff, 8'hff, 8'h41);
    rd_chk(8'h20, 8'hff, 8'h00);
    halt = 1'b1;
    for (k = 0; k < 20 && run !== 1'b0; k++) @(negedge clk_sys_i);
    halt = 1'b0;
    repeat (30) @(negedge clk_sys_i);
    check("halt", 16'h0000, {15'h0000, run});
    do_rst(1'b0);
    rd_chk(8'hff, 8'hff, 8'h11);
    $display("test reset done");
    final_report;
  end
endmodule
